// ---- include/sync_serial_pkg.sv ----
// shared constants for the synchronous serial mode and status block
package sync_serial_pkg;
  // bus geometry
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  CTRL_OFS       = 4'h0;   // serial_mode_and_status_word
  localparam logic [3:0]  TXB_OFS        = 4'h4;   // tx_holding_buffer
  localparam logic [3:0]  RXB_OFS        = 4'h8;   // rx_holding_buffer (read only)
  localparam logic [3:0]  BAUD_OFS       = 4'hc;   // half period reload for master clock
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // control word, both views
  localparam int          ENABLE_BIT     = 15;
  localparam int          MASTER_SEL_BIT = 14;
  localparam int          AUTO_CLR_BIT   = 12;     // configuration view
  localparam int          BAUD_CHK_BIT   = 11;
  localparam int          SAMP_CHK_BIT   = 10;
  localparam int          OVR_CHK_BIT    = 9;
  localparam int          UND_CHK_BIT    = 8;
  localparam int          LOOP_BIT       = 7;
  localparam int          IDLE_LVL_BIT   = 6;
  localparam int          EDGE_SEL_BIT   = 5;
  localparam int          ORDER_BIT      = 4;
  localparam int          WIDTH_MSB      = 3;      // frame_width_sel is [3:0]
  localparam int          ACTIVE_BIT     = 12;     // operating view
  localparam int          FLAG_LSB       = 8;      // flags occupy [11:8]
  localparam int          F_BAUD         = 3;      // index inside the flag nibble
  localparam int          F_GLITCH       = 2;
  localparam int          F_OVR          = 1;
  localparam int          F_UND          = 0;
  localparam logic [15:0] CFG_MASK       = 16'h1fff;

  // reset values
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] BAUD_RESET     = 16'h0001;
  localparam logic [15:0] BUF_RESET      = 16'h0000;

  // slave rate check: error beyond this factor either way
  localparam int          BAUD_FACTOR_SH = 1;      // factor 2 as a shift
endpackage

// ---- logic/sync_serial_mode_control.sv ----
// synchronous serial shift unit with dual-view mode and status word, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module sync_serial_mode_control
  import sync_serial_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  input  wire logic              i_clock_pin,
  output logic                   o_master_clock_out,
  output logic                   o_clock_pin_oe,
  input  wire logic              i_master_out_pin,
  output logic                   o_master_out_pin,
  output logic                   o_master_out_pin_oe,
  input  wire logic              i_master_in_pin,
  output logic                   o_master_in_pin,
  output logic                   o_master_in_pin_oe,
  output logic                   o_tx_reload_request,
  output logic                   o_rx_full_request
);

  // picks a frame bit position; data stays right aligned either way
  function automatic logic [3:0] pos(input logic [4:0] k, input logic msb_first,
                                     input logic [3:0] last);
    pos = msb_first ? (last - k[3:0]) : k[3:0];
  endfunction

  // pin synchronisers, first stage read only by the second
  logic        clk_s1_q, clk_s2_q, clk_s3_q;   // s3 is history for edge finding
  logic        mo_s1_q,  mo_s2_q;              // master_out_pin sampled
  logic        mi_s1_q,  mi_s2_q;              // master_in_pin sampled

  // bus state
  logic              aw_have_q, aw_have_d;     // write address held
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic              w_have_q,  w_have_d;      // write data held
  logic [15:0]       w_data_q,  w_data_d;
  logic [1:0]        w_strb_q,  w_strb_d;      // only the low two lanes matter
  logic              awready_q, awready_d;
  logic              wready_q,  wready_d;
  logic              bvalid_q,  bvalid_d;
  logic [1:0]        bresp_q,   bresp_d;
  logic              arready_q, arready_d;
  logic              rvalid_q,  rvalid_d;
  logic [31:0]       rdata_q,   rdata_d;
  logic [1:0]        rresp_q,   rresp_d;

  // mode word and engine state
  logic        enable_q,   enable_d;           // view select and run permission
  logic        master_q,   master_d;           // clock_master_sel
  logic [15:0] cfg_q,      cfg_d;              // configuration view, bits 12..0
  logic        active_q,   active_d;           // transfer_active
  logic [3:0]  flags_q,    flags_d;            // baud, glitch, overrun, underrun
  logic [4:0]  count_q,    count_d;            // bits latched, shift_count low 4
  logic [4:0]  out_idx_q,  out_idx_d;          // bits driven so far
  logic        run_q,      run_d;              // frame actually shifting
  logic [15:0] tx_sh_q,    tx_sh_d;
  logic [15:0] rx_sh_q,    rx_sh_d;
  logic [15:0] txb_q,      txb_d;              // tx_holding_buffer
  logic        txb_full_q, txb_full_d;
  logic [15:0] rxb_q,      rxb_d;              // rx_holding_buffer
  logic        rxb_unread_q, rxb_unread_d;
  logic [15:0] baud_q,     baud_d;             // master half period minus one
  logic [15:0] half_cnt_q, half_cnt_d;
  logic        phase_q,    phase_d;            // 1 while clock away from idle
  logic [19:0] meas_q,     meas_d;             // slave bit period measurement
  logic        latch_chk_q, latch_chk_d;       // check input one cycle after latch
  logic        latch_bit_q, latch_bit_d;
  logic        dout_q,     dout_d;             // serial data driven out
  logic        clk_out_q,  clk_out_d;
  logic        clk_oe_q,   clk_oe_d;
  logic        mo_oe_q,    mo_oe_d;
  logic        mi_oe_q,    mi_oe_d;
  logic        txreq_q,    txreq_d;
  logic        rxreq_q,    rxreq_d;

  // combinational helpers
  logic [15:0] ctrl_view;                      // word as software sees it now
  logic [15:0] wmask;
  logic [15:0] nv;                             // merged write value
  logic        wr_en, wr_ctrl;
  logic [15:0] wr_cfg_val;
  logic        in_bit, m_tick, s_lvl, s_prev;
  logic        lead_ev, trail_ev, out_ev, lat_ev, go, live, fin;
  logic [4:0]  width;
  logic [19:0] expect_per;
  logic [3:0]  flag_set;

  // synchronisers, no reset needed: they settle within three cycles
  always_ff @(posedge i_clk) begin
    clk_s1_q <= i_clock_pin;
    clk_s2_q <= clk_s1_q;
    clk_s3_q <= clk_s2_q;
    mo_s1_q  <= i_master_out_pin;
    mo_s2_q  <= mo_s1_q;
    mi_s1_q  <= i_master_in_pin;
    mi_s2_q  <= mi_s1_q;
  end

  // read view depends on the enable bit as stored now
  always_comb begin
    if (enable_q) begin
      ctrl_view = {1'b1, master_q, 1'b0, active_q, flags_q, 4'h0, count_q[3:0]};
    end else begin
      ctrl_view = {1'b0, master_q, 1'b0, cfg_q[12:0]};
    end
  end

  // next state for bus and engine together, since writes steer the engine
  always_comb begin
    aw_have_d = aw_have_q;  aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;   w_data_d  = w_data_q;   w_strb_d = w_strb_q;
    bvalid_d  = bvalid_q;   bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;   rdata_d   = rdata_q;    rresp_d  = rresp_q;
    enable_d  = enable_q;   master_d  = master_q;   cfg_d    = cfg_q;
    active_d  = active_q;   flags_d   = flags_q;    count_d  = count_q;
    out_idx_d = out_idx_q;  run_d     = run_q;      tx_sh_d  = tx_sh_q;
    rx_sh_d   = rx_sh_q;    txb_d     = txb_q;      txb_full_d = txb_full_q;
    rxb_d     = rxb_q;      rxb_unread_d = rxb_unread_q;
    baud_d    = baud_q;     half_cnt_d = half_cnt_q; phase_d = phase_q;
    meas_d    = meas_q;     latch_bit_d = latch_bit_q; dout_d = dout_q;
    latch_chk_d = 1'b0;
    txreq_d   = 1'b0;
    rxreq_d   = 1'b0;
    flag_set  = 4'h0;
    wr_ctrl   = 1'b0;
    wr_cfg_val = 16'h0000;
    nv        = 16'h0000;

    // read channel; a read of the rx buffer marks it consumed
    if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
    if (i_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (i_araddr)
        CTRL_OFS: rdata_d = {16'h0000, ctrl_view};
        TXB_OFS:  rdata_d = {16'h0000, txb_q};
        RXB_OFS: begin
          rdata_d      = {16'h0000, rxb_q};
          rxb_unread_d = 1'b0;
        end
        BAUD_OFS: rdata_d = {16'h0000, baud_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;            // unmapped address
        end
      endcase
    end

    // pin view: loop routes own output back in
    in_bit   = cfg_q[LOOP_BIT] ? dout_q : (master_q ? mi_s2_q : mo_s2_q);
    width    = {1'b0, cfg_q[WIDTH_MSB:0]} + 5'h01;
    m_tick   = run_q && master_q && (half_cnt_q == 16'h0000);
    s_lvl    = clk_s2_q ^ cfg_q[IDLE_LVL_BIT];   // 0 means idle level
    s_prev   = clk_s3_q ^ cfg_q[IDLE_LVL_BIT];
    lead_ev  = master_q ? (m_tick && !phase_q) : (s_lvl && !s_prev);
    trail_ev = master_q ? (m_tick && phase_q) : (!s_lvl && s_prev);
    out_ev   = cfg_q[EDGE_SEL_BIT] ? trail_ev : lead_ev;
    lat_ev   = cfg_q[EDGE_SEL_BIT] ? lead_ev : trail_ev;
    expect_per = ({4'h0, baud_q} + 20'h00001) << 1;

    // master clock generator, half period from the baud register
    if (run_q && master_q) begin
      if (m_tick) begin
        half_cnt_d = baud_q;
        phase_d    = !phase_q;
      end else begin
        half_cnt_d = half_cnt_q - 16'h0001;
      end
    end

    // slave with late-phase edges must show its first bit before the clock
    if (enable_q && !run_q && !master_q && cfg_q[EDGE_SEL_BIT] && txb_full_q) begin
      dout_d = txb_q[pos(5'h00, cfg_q[ORDER_BIT], cfg_q[WIDTH_MSB:0])];
    end

    // frame start: master once the tx buffer holds a word, slave on its first active clock edge
    go = enable_q && !run_q && (master_q ? txb_full_q : lead_ev);
    if (go) begin
      run_d      = 1'b1;
      active_d   = 1'b1;
      txreq_d    = 1'b1;
      count_d    = 5'h00;
      out_idx_d  = 5'h00;
      meas_d     = 20'h00000;
      half_cnt_d = baud_q;
      phase_d    = 1'b0;
      if (txb_full_q) begin
        tx_sh_d    = txb_q;
        txb_full_d = 1'b0;
      end else if (cfg_q[UND_CHK_BIT]) begin
        flag_set[F_UND] = 1'b1;
      end
      if (cfg_q[EDGE_SEL_BIT]) begin
        dout_d    = tx_sh_d[pos(5'h00, cfg_q[ORDER_BIT], cfg_q[WIDTH_MSB:0])];
        out_idx_d = 5'h01;
      end
    end

    // shift and latch; the last driven bit simply stays on the line
    live = run_q || go;
    if (live && out_ev && (out_idx_d < width)) begin
      dout_d    = tx_sh_d[pos(out_idx_d, cfg_q[ORDER_BIT], cfg_q[WIDTH_MSB:0])];
      out_idx_d = out_idx_d + 5'h01;
    end
    if (live && lat_ev && (count_d < width)) begin
      rx_sh_d[pos(count_d, cfg_q[ORDER_BIT], cfg_q[WIDTH_MSB:0])] = in_bit;
      count_d     = count_d + 5'h01;
      latch_chk_d = 1'b1;
      latch_bit_d = in_bit;
    end

    // sampled bit must still hold one cycle after the latch edge
    if (latch_chk_q && (in_bit != latch_bit_q) && cfg_q[SAMP_CHK_BIT]) begin
      flag_set[F_GLITCH] = 1'b1;
    end

    // master finishes when its clock is back at idle
    fin = live && (count_d == width) && (master_q ? trail_ev : lat_ev);
    if (fin) begin
      run_d        = 1'b0;
      phase_d      = 1'b0;
      rxb_d        = rx_sh_d;
      rxreq_d      = 1'b1;
      if (rxb_unread_d && cfg_q[OVR_CHK_BIT]) begin
        flag_set[F_OVR] = 1'b1;
      end
      rxb_unread_d = 1'b1;
      active_d     = txb_full_d;
    end

    // slave rate check between leading edges of one frame
    if (run_q && !master_q) begin
      if (lead_ev) begin
        meas_d = 20'h00000;
        if (cfg_q[BAUD_CHK_BIT] && ((meas_q > (expect_per << BAUD_FACTOR_SH))
            || (meas_q < (expect_per >> BAUD_FACTOR_SH)))) begin
          flag_set[F_BAUD] = 1'b1;
          if (cfg_q[AUTO_CLR_BIT]) begin
            run_d     = 1'b0;
            active_d  = 1'b0;
            count_d   = 5'h00;
            out_idx_d = 5'h00;
            rxreq_d   = 1'b0;
          end
        end
      end else if (meas_q != 20'hfffff) begin
        meas_d = meas_q + 20'h00001;
      end
    end

    // write channel: address and data in either order, response after both
    if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    if (i_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = i_awaddr;
    end
    if (i_wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = i_wdata[15:0];
      w_strb_d = i_wstrb[1:0];
    end
    wr_en = aw_have_d && w_have_d && !bvalid_d;
    wmask = {{8{w_strb_d[1]}}, {8{w_strb_d[0]}}};
    if (wr_en) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (aw_addr_d)
        CTRL_OFS: begin
          wr_ctrl = 1'b1;
          nv = (ctrl_view & ~wmask) | (w_data_d & wmask);
          wr_cfg_val = nv & CFG_MASK;
          if (enable_q) begin
            flags_d = flags_q & nv[FLAG_LSB+3:FLAG_LSB]; // zero clears
          end else begin
            cfg_d = wr_cfg_val;
          end
          enable_d = nv[ENABLE_BIT];
          master_d = nv[MASTER_SEL_BIT];
        end
        TXB_OFS: begin
          txb_d      = (txb_q & ~wmask) | (w_data_d & wmask);
          txb_full_d = 1'b1;
        end
        RXB_OFS: bresp_d = RESP_OKAY;           // read only, write dropped
        BAUD_OFS: baud_d = (baud_q & ~wmask) | (w_data_d & wmask);
        default: bresp_d = RESP_SLVERR;
      endcase
    end

    // a hardware set in the clearing cycle wins
    flags_d = flags_d | flag_set;

    // switching off halts shifting at once and drops busy
    if (!enable_d) begin
      run_d     = 1'b0;
      active_d  = 1'b0;
      phase_d   = 1'b0;
      count_d   = 5'h00;
      out_idx_d = 5'h00;
    end

    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
    clk_out_d = cfg_d[IDLE_LVL_BIT] ^ phase_d;
    clk_oe_d  = enable_d && master_d;
    mo_oe_d   = enable_d && master_d;
    mi_oe_d   = enable_d && !master_d;
  end

  // register everything; synchronous active-low reset
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      aw_have_q <= 1'b0;   aw_addr_q <= '0;      w_have_q <= 1'b0;
      w_data_q  <= BUF_RESET; w_strb_q <= 2'h0;
      awready_q <= 1'b0;   wready_q  <= 1'b0;    bvalid_q <= 1'b0;
      bresp_q   <= RESP_OKAY; arready_q <= 1'b0; rvalid_q <= 1'b0;
      rdata_q   <= 32'h0000_0000; rresp_q <= RESP_OKAY;
      enable_q  <= CTRL_RESET[ENABLE_BIT];
      master_q  <= CTRL_RESET[MASTER_SEL_BIT];
      cfg_q     <= CTRL_RESET & CFG_MASK;
      active_q  <= 1'b0;   flags_q   <= 4'h0;    count_q  <= 5'h00;
      out_idx_q <= 5'h00;  run_q     <= 1'b0;    tx_sh_q  <= BUF_RESET;
      rx_sh_q   <= BUF_RESET; txb_q  <= BUF_RESET; txb_full_q <= 1'b0;
      rxb_q     <= BUF_RESET; rxb_unread_q <= 1'b0; baud_q <= BAUD_RESET;
      half_cnt_q <= 16'h0000; phase_q <= 1'b0;   meas_q   <= 20'h00000;
      latch_chk_q <= 1'b0; latch_bit_q <= 1'b0;  dout_q   <= 1'b0;
      clk_out_q <= 1'b0;   clk_oe_q  <= 1'b0;    mo_oe_q  <= 1'b0;
      mi_oe_q   <= 1'b0;   txreq_q   <= 1'b0;    rxreq_q  <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d; aw_addr_q <= aw_addr_d; w_have_q <= w_have_d;
      w_data_q  <= w_data_d;  w_strb_q  <= w_strb_d;
      awready_q <= awready_d; wready_q  <= wready_d;  bvalid_q <= bvalid_d;
      bresp_q   <= bresp_d;   arready_q <= arready_d; rvalid_q <= rvalid_d;
      rdata_q   <= rdata_d;   rresp_q   <= rresp_d;
      enable_q  <= enable_d;  master_q  <= master_d;  cfg_q    <= cfg_d;
      active_q  <= active_d;  flags_q   <= flags_d;   count_q  <= count_d;
      out_idx_q <= out_idx_d; run_q     <= run_d;     tx_sh_q  <= tx_sh_d;
      rx_sh_q   <= rx_sh_d;   txb_q     <= txb_d;     txb_full_q <= txb_full_d;
      rxb_q     <= rxb_d;     rxb_unread_q <= rxb_unread_d; baud_q <= baud_d;
      half_cnt_q <= half_cnt_d; phase_q <= phase_d;   meas_q   <= meas_d;
      latch_chk_q <= latch_chk_d; latch_bit_q <= latch_bit_d; dout_q <= dout_d;
      clk_out_q <= clk_out_d; clk_oe_q  <= clk_oe_d;  mo_oe_q  <= mo_oe_d;
      mi_oe_q   <= mi_oe_d;   txreq_q   <= txreq_d;   rxreq_q  <= rxreq_d;
    end
  end

  // ports straight from flops
  assign o_awready           = awready_q;
  assign o_wready            = wready_q;
  assign o_bvalid            = bvalid_q;
  assign o_bresp             = bresp_q;
  assign o_arready           = arready_q;
  assign o_rvalid            = rvalid_q;
  assign o_rdata             = rdata_q;
  assign o_rresp             = rresp_q;
  assign o_master_clock_out  = clk_out_q;
  assign o_clock_pin_oe      = clk_oe_q;
  assign o_master_out_pin    = dout_q;
  assign o_master_out_pin_oe = mo_oe_q;
  assign o_master_in_pin     = dout_q;
  assign o_master_in_pin_oe  = mi_oe_q;
  assign o_tx_reload_request = txreq_q;
  assign o_rx_full_request   = rxreq_q;

  // checks next to the logic they guard
  property p_halt_when_off;
    @(posedge i_clk) disable iff (!i_nrst) !enable_q |=> !run_q;
  endproperty
  a_halt_when_off: assert property (p_halt_when_off) else $error("shifting while off");

  property p_cfg_then_on;
    @(posedge i_clk) disable iff (!i_nrst)
      (wr_ctrl && !enable_q && nv[ENABLE_BIT]) |=> (enable_q && cfg_q == $past(wr_cfg_val));
  endproperty
  a_cfg_then_on: assert property (p_cfg_then_on) else $error("config write lost on enable");

  property p_clock_drive;
    @(posedge i_clk) disable iff (!i_nrst) o_clock_pin_oe == (enable_q && master_q);
  endproperty
  a_clock_drive: assert property (p_clock_drive) else $error("clock pin drive wrong");

  property p_idle_level;
    @(posedge i_clk) disable iff (!i_nrst)
      (!run_q && enable_q && master_q) |-> o_master_clock_out == cfg_q[IDLE_LVL_BIT];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong");

  property p_busy_cover;
    @(posedge i_clk) disable iff (!i_nrst) run_q |-> active_q;
  endproperty
  a_busy_cover: assert property (p_busy_cover) else $error("busy low during transfer");

  property p_reload_at_start;
    @(posedge i_clk) disable iff (!i_nrst)
      o_tx_reload_request |-> (run_q && active_q && $past(!run_q || fin));
  endproperty
  a_reload_at_start: assert property (p_reload_at_start) else $error("reload not at start");

  property p_rx_full_end;
    @(posedge i_clk) disable iff (!i_nrst)
      o_rx_full_request |-> (!run_q && rxb_unread_q && $past(count_d) == $past(width));
  endproperty
  a_rx_full_end: assert property (p_rx_full_end) else $error("rx request off frame end");

  property p_count_bound;
    @(posedge i_clk) disable iff (!i_nrst) run_q |-> count_q <= width;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("shift count past width");

  property p_ovr_gated;
    @(posedge i_clk) disable iff (!i_nrst) $rose(flags_q[F_OVR]) |-> cfg_q[OVR_CHK_BIT];
  endproperty
  a_ovr_gated: assert property (p_ovr_gated) else $error("overrun flag without check");

  property p_reset_zero;
    @(posedge i_clk) disable iff (!i_nrst)
      $rose(i_nrst) |-> (!enable_q && !master_q && cfg_q == 16'h0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("word not zero after reset");

endmodule
`default_nettype wire

// ---- verification/serial_slave_model.sv ----
// far-side serial slave model for the mode control bench
`timescale 1ns/1ps
`default_nettype none
module serial_slave_model (
  input  wire logic        i_sclk,
  input  wire logic        i_cpol,
  input  wire logic        i_cpha,
  input  wire logic        i_mosi,
  input  wire logic        i_start,
  input  wire logic [15:0] i_load,
  output logic             o_miso = 1'b0,
  output logic [15:0]      o_got
);
  logic [15:0] sr;                    // bits still to send, top first
  wire logic   lead = i_sclk ^ i_cpol; // high between leading and trailing edge
  // reload; late phase must show its first bit before any clock edge
  always @(posedge i_start) begin
    sr = i_load;
    o_got = 16'h0;
    o_miso = i_cpha ? sr[15] : ~o_miso; // stale bit is not kept
    if (i_cpha) sr = sr << 1;
  end
  // shift on one edge, latch on the other
  always @(lead) begin
    if (lead ^ i_cpha) begin
      o_miso = sr[15];
      sr = sr << 1;
    end else o_got = {o_got[14:0], i_mosi};
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench: random frames against a far-side slave model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sync_serial_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, st = 1'b0, po = 1'b0, ph = 1'b0, hb = 1'b0;
  logic        aw = 1'b0, w = 1'b0, ar = 1'b0, bq = 1'b0, rq = 1'b0;
  logic [3:0]  aa = 4'h0, ra = 4'h0, bm;
  logic [31:0] wd = 32'h0, rd, seed = 32'hf835;
  logic [15:0] ld = 16'h0, got;
  logic        awr, wr, bv, arr, rv, rx, tq, cko, coe, mo, moe, miso, sclk;
  int          miscompares = 0, check_count = 0, tr = 0;
  always #12.5 clk = ~clk;
  // counts transmit reload pulses, one expected per tx buffer write
  always @(posedge clk) if (tq === 1'b1) tr <= tr + 1;
  assign sclk = coe ? cko : po; // released clock pin rests at idle level
  sync_serial_mode_control i_sync_serial_mode_control (
    .i_clk(clk), .i_nrst(nrst), .i_awvalid(aw), .o_awready(awr), .i_awaddr(aa),
    .i_wvalid(w), .o_wready(wr), .i_wdata(wd), .i_wstrb(4'h3), .o_bvalid(bv),
    .i_bready(bq), .o_bresp(), .i_arvalid(ar), .o_arready(arr), .i_araddr(ra),
    .o_rvalid(rv), .i_rready(rq), .o_rdata(rd), .o_rresp(), .i_clock_pin(sclk),
    .o_master_clock_out(cko), .o_clock_pin_oe(coe), .i_master_out_pin(moe ? mo : 1'b1),
    .o_master_out_pin(mo), .o_master_out_pin_oe(moe), .i_master_in_pin(miso),
    .o_master_in_pin(), .o_master_in_pin_oe(), .o_tx_reload_request(tq),
    .o_rx_full_request(rx));
  serial_slave_model i_serial_slave_model (.i_sclk(sclk), .i_cpol(po), .i_cpha(ph),
    .i_mosi(mo), .i_start(st), .i_load(ld), .o_miso(miso), .o_got(got));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one edge of a bounded wait; a hang counts and ends the run
  task automatic tick(inout int n);
    @(posedge clk);
    if (++n > 2000) begin
      miscompares++;
      wrap_up();
    end
  endtask
  // one AXI4-Lite write or read, readies and answers taken at the rising edge
  task automatic bus(input logic wt, input logic [3:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int   n;
    logic ha, hw, hx, hr;
    n = 0;
    if (wt) begin
      aw <= 1'b1; w <= 1'b1; bq <= 1'b1; aa <= a; wd <= {16'h0, d};
    end else begin
      ar <= 1'b1; rq <= 1'b1; ra <= a;
    end
    do begin
      tick(n);
      {ha, hw, hx} = {awr & aw, wr & w, arr & ar};
      hr = (bv & bq) | (rv & rq);
      if (hr) q = rd;
      if (ha) aw <= 1'b0;
      if (hw) w <= 1'b0;
      if (hx) ar <= 1'b0;
    end while (!hr);
    bq <= 1'b0;
    rq <= 1'b0;
    @(posedge clk); // keeps the next request off this edge
  endtask
  initial begin
    logic [31:0] q;
    logic [15:0] tx, eg, er;
    int          n, k, b, wn;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, CTRL_OFS, 16'h0, q); chk(q, 32'h0);
    // half period of four cycles leaves room for the two-flop data input
    bus(1, BAUD_OFS, 16'h3, q);
    // every polarity, phase and bit order, with widths of 2 and 16 bits and random even widths in between
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      {hb, po, ph} <= c[2:0];
      bm = (c == 0) ? 4'h1 : (c == 7) ? 4'hf : seed[3:0] | 4'h1;
      bus(1, CTRL_OFS, 16'h0, q);
      bus(1, CTRL_OFS, {8'hc2, 1'b0, po, ph, hb, bm}, q);
      bus(0, CTRL_OFS, 16'h0, q); chk(q, 32'hc000);
      ld = seed[31:16];
      st <= 1'b1;
      @(posedge clk);
      st <= 1'b0;
      tx = seed[15:0] ^ seed[31:16];
      bus(1, TXB_OFS, tx, q);
      n = 0;
      do tick(n); while (rx !== 1'b1);
      wn = bm + 1;
      eg = 16'h0;
      er = 16'h0;
      for (k = 0; k < wn; k++) begin
        b = hb ? wn - 1 - k : k;
        eg[wn - 1 - k] = tx[b];
        er[b] = ld[15 - k];
      end
      repeat (2) @(posedge clk);
      chk({16'h0, got}, {16'h0, eg});
      chk({31'h0, sclk}, {31'h0, po});
      chk({31'h0, mo}, {31'h0, tx[hb ? 0 : wn - 1]});
      bus(0, RXB_OFS, 16'h0, q); chk(q & ((32'h1 << wn) - 1), {16'h0, er});
      $display("frame %0d done", c);
    end
    // two frames with no read between them: the second one overruns
    for (k = 0; k < 2; k++) begin
      bus(1, TXB_OFS, seed[15:0], q);
      n = 0;
      do tick(n); while (rx !== 1'b1);
    end
    bus(0, CTRL_OFS, 16'h0, q); chk(q, 32'hc200);
    bus(1, CTRL_OFS, 16'hc000, q);
    bus(0, CTRL_OFS, 16'h0, q); chk(q, 32'hc000);
    chk(tr, 32'd10);
    $display("overrun test done");
    wrap_up();
  end
endmodule
`default_nettype wire
